// ==== sim/uep_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module uep_monitor
(
    input wire logic I_CLK_SYS, // system clock
    input wire logic I_SRST, // synchronous reset
    input wire logic in_token, // IN token pulse
    input wire logic ack, // host acknowledge pulse
    input wire logic resp_valid, // answer strobe
    input wire logic [1:0] resp_code // answer code
);
    // ********************
    // link sequences
    // ********************
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_SRST);
    sequence data_ans;
        resp_valid && (resp_code == uep_pkg::RESP_DATA0 || resp_code == uep_pkg::RESP_DATA1);
    endsequence
    sequence data_acked;
        data_ans ##2 ack;
    endsequence
    // ********************
    // link checks
    // ********************
    tok_answer_a: assert property (in_token |=> resp_valid)
        else $error("token not answered next cycle");
    ans_cause_a: assert property (resp_valid |-> $past(in_token))
        else $error("answer without token");
    answer_pulse_a: assert property (resp_valid |=> !resp_valid)
        else $error("answer longer than one cycle");
    tok_pulse_a: assert property (in_token |=> !in_token)
        else $error("token longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(resp_valid, 2) && $past(resp_code, 2) inside
        {uep_pkg::RESP_DATA0, uep_pkg::RESP_DATA1})
        else $error("ack without data answer");
    stall_noack_a: assert property (resp_valid && resp_code == uep_pkg::RESP_STALL |=> !ack)
        else $error("ack after stall");
    nak_noack_a: assert property (resp_valid && resp_code == uep_pkg::RESP_NAK |=> !ack [*2])
        else $error("ack after nak");
    ack_pulse_a: assert property (data_acked |=> !ack)
        else $error("ack longer than one cycle");
    reset_idle_a: assert property (disable iff (1'b0) I_SRST |=> !resp_valid
        && resp_code == uep_pkg::RESP_NAK)
        else $error("link busy in reset");
    data_acked_c: cover property (data_acked);
endmodule // uep_monitor
`default_nettype wire

// ==== sim/usb_device_tx_endpoint_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_device_tx_endpoint_ctrl_tb;
    // ********************
    // signals
    // ********************
    typedef struct {string n; logic [33:0] v;} uep_note_t;
    localparam logic [3:0] ST = uep_pkg::OFS_STAT;
    localparam logic [3:0] LA = uep_pkg::OFS_LAST;
    logic clk = 1'b0, srst = 1'b1, we = 1'b0, irq_en = 1'b1, peek = 1'b0, shr = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic [3:0] awa = 4'h0, ara = 4'h0, ic = 4'h0, fc = 4'h0;
    logic [31:0] wdat = 32'h0, lfsr = 32'h6028b8e3, rdat;
    logic [15:0] csr;
    logic [1:0] cnt, br, rr;
    logic d_irq, h_irq, dma, dir, frst, awr, wr, bv, arr, rv;
    int n_fail = 0, n_tests = 0, cyc = 0;
    uep_note_t q[$];
    uep_link_if link();
    uep_dev_end uep_dev_end_inst (.link(link), .I_CLK_SYS(clk), .I_SRST(srst), .I_CSR_WE(we),
        .I_CSR_WDATA(wd), .O_CSR_RDATA(csr), .I_SHARED_FIFO(shr), .I_IRQ_EN(irq_en),
        .O_IRQ(d_irq), .O_DMA_REQ(dma), .O_DIR_TX(dir), .O_FIFO_RST(frst), .O_PKT_COUNT(cnt));
    uep_host_end uep_host_end_inst (.link(link), .I_CLK_SYS(clk), .I_SRST(srst),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdat),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rre), .O_IRQ(h_irq));
    uep_monitor uep_monitor_inst (.I_CLK_SYS(clk), .I_SRST(srst), .in_token(link.in_token),
        .ack(link.ack), .resp_valid(link.resp_valid), .resp_code(link.resp_code));
    initial forever #2 clk = ~clk;
    // ********************
    // checking
    // ********************
    task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic take(input logic [33:0] s);
        uep_note_t e;
        e = q.pop_front();
        check(e.n, s, e.v);
    endtask
    task automatic final_report;
        if (q.size() != 0) n_fail++;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (d_irq) ic <= ic + 4'h1;
        if (frst) fc <= fc + 4'h1;
        if (bv && bre) take({br, 32'h0});
        if (rv && rre) take({rr, rdat});
        if (peek) take({5'h0, h_irq, dma, dir, cnt, ic, fc, csr});
        if (cyc == 6000)
        begin
            n_fail++;
            final_report();
        end
    end
    // ********************
    // drivers
    // ********************
    task automatic csr_wr(input logic [15:0] v);
        @(posedge clk);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        we <= 1'b1;
        wd <= v | (lfsr[15:0] & 16'h8380); // reserved bits get noise, style bit kept 0
        @(posedge clk);
        we <= 1'b0;
    endtask
    // st nibbles: {irq,dma,dir}, count, irq pulses, fifo resets
    task automatic look(input string n, input logic [15:0] st, input logic [15:0] v);
        repeat (3) @(posedge clk);
        q.push_back('{n, {5'h0, st[14:12], st[9:8], st[7:0], v}});
        peek <= 1'b1;
        @(posedge clk);
        peek <= 1'b0;
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic [2:0] hs;
        hs = 3'b000;
        q.push_back('{"bresp", 34'h0});
        @(posedge clk);
        awa <= a;
        wdat <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!hs[0])
        begin
            @(negedge clk);
            hs = {awv & awr, wv & wr, bv & bre};
            @(posedge clk);
            if (hs[2]) awv <= 1'b0;
            if (hs[1]) wv <= 1'b0;
            if (hs[0]) bre <= 1'b0;
        end
    endtask
    task automatic axi_rd(input string n, input logic [3:0] a, input logic [33:0] e);
        logic [1:0] hs;
        hs = 2'b00;
        q.push_back('{n, e});
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        while (!hs[0])
        begin
            @(negedge clk);
            hs = {arv & arr, rv & rre};
            @(posedge clk);
            if (hs[1]) arv <= 1'b0;
            if (hs[0]) rre <= 1'b0;
        end
    endtask
    task automatic tok(input logic [31:0] c);
        axi_wr(uep_pkg::OFS_CTRL, c);
        do @(negedge clk); while (link.resp_valid !== 1'b1);
        repeat (6) @(posedge clk);
    endtask
    // ********************
    // scenarios
    // ********************
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        look("reset", 16'h0000, 16'h0000);
        axi_rd("stat", ST, 34'h0);
        axi_wr(uep_pkg::OFS_MASK, 32'h7);
        axi_rd("mask", uep_pkg::OFS_MASK, 34'h7);
        axi_rd("hole", 4'h6, 34'h200000000);
        tok(32'h1);
        axi_rd("last", LA, 34'h0);
        look("shared", 16'h4000, 16'h0000);
        axi_rd("stat", ST, 34'h4);
        shr <= 1'b0;
        look("own", 16'h1000, 16'h0000);
        shr <= 1'b1;
        csr_wr(16'h2000);
        tok(32'h1);
        look("under", 16'h5000, 16'h2004);
        axi_rd("stat", ST, 34'h4);
        csr_wr(16'h3000);
        look("dma", 16'h3000, 16'h3000);
        csr_wr(16'h3001);
        look("load", 16'h1100, 16'h3003);
        csr_wr(16'h3001);
        look("reload", 16'h1100, 16'h3003);
        tok(32'h3);
        axi_rd("last", LA, 34'h1);
        axi_rd("stat", ST, 34'h1);
        look("sent", 16'h3010, 16'h3002);
        csr_wr(16'h3041);
        look("zero", 16'h1110, 16'h3003);
        tok(32'h3);
        axi_rd("last", LA, 34'h1);
        csr_wr(16'h3001);
        tok(32'h1);
        axi_rd("last", LA, 34'h2);
        tok(32'h1);
        axi_rd("last", LA, 34'h2);
        axi_rd("stat", ST, 34'h1);
        look("retry", 16'h1120, 16'h3003);
        irq_en <= 1'b0;
        csr_wr(16'h300b);
        look("discard", 16'h3021, 16'h3002);
        csr_wr(16'h3008); // second discard
        look("refused", 16'h3021, 16'h3000);
        csr_wr(16'h3001);
        csr_wr(16'h3013);
        tok(32'h1);
        axi_rd("last", LA, 34'h3);
        axi_rd("stat", ST, 34'h2);
        look("halt", 16'h3022, 16'h3032);
        csr_wr(16'h7013);
        tok(32'h1);
        axi_rd("last", LA, 34'h2);
        look("iso", 16'h7022, 16'h7012);
        irq_en <= 1'b1;
        csr_wr(16'h3803);
        tok(32'h1);
        axi_rd("last", LA, 34'h2);
        look("force", 16'h7032, 16'h3802);
        csr_wr(16'h3001);
        tok(32'h3);
        axi_rd("last", LA, 34'h1);
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule // usb_device_tx_endpoint_ctrl_tb
`default_nettype wire

// ==== verilog/uep_dev_end.sv ====
// Overview of operation
// R1: bit 14 selects isochronous, else bulk/interrupt
// R2: bit 13 sets direction for shared FIFO
// R3: DMA requests only while bit 12 set
// R4: force bit flips toggle, drops packet regardless
// R5: software keeps DMA style bit at zero
// R6: toggle-zero strobe clears toggle, reads zero
// R7: after STALL set flag, flush, clear loaded
// R8: halt request answers IN tokens with STALL
// R9: halt request ignored for isochronous endpoint
// R10: discard write drops packet, clears loaded
// R11: discard ignored unless packet loaded
// R12: double buffer may need two discards
// R13: IN token without packet sets underrun flag
// R14: queue flag set while packet in FIFO
// R15: software sets loaded, device clears after send
// R16: loaded falling raises enabled endpoint interrupt
// R17: all fields reset zero, reserved read zero
// R18: toggle advances after each acknowledged packet
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uep_dev_end
#(
    parameter int SLOTS = uep_pkg::PKT_SLOTS
)
(
    uep_link_if.dev link, // token link to the host
    input wire logic I_CLK_SYS, // system clock
    input wire logic I_SRST, // synchronous reset, active high
    input wire logic I_CSR_WE, // register write strobe
    input wire logic [15:0] I_CSR_WDATA, // register write data
    output logic [15:0] O_CSR_RDATA, // register read view
    input wire logic I_SHARED_FIFO, // FIFO shared by both directions
    input wire logic I_IRQ_EN, // endpoint interrupt enable
    output logic O_IRQ, // endpoint interrupt pulse
    output logic O_DMA_REQ, // DMA request for a new packet
    output logic O_DIR_TX, // endpoint works as transmitter
    output logic O_FIFO_RST, // FIFO pointer reset pulse
    output logic [1:0] O_PKT_COUNT // packets in the FIFO
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic iso_q, dir_tx_q, dma_en_q, tog_force_q, dma_style_q;
    logic halt_rep_q, halt_req_q, underrun_q, has_pkt_q, loaded_q;
    logic loaded_d, has_pkt_d;
    logic toggle_q, wait_ack_q;
    logic [1:0] cnt_q, cnt_d;
    logic [15:0] wd;
    logic tx_active, stall_now, send_now, under_now, sent_done, flush_now;
    logic load_now, tog_flip, drop_one;

    assign wd = I_CSR_WDATA;

    // ****************************************************************
    // link events
    // ****************************************************************
    assign tx_active = !I_SHARED_FIFO || dir_tx_q; // see R2
    assign stall_now = link.in_token && tx_active && halt_req_q && !iso_q; // see R8 see R9
    assign send_now = link.in_token && tx_active && !stall_now && loaded_q;
    assign under_now = link.in_token && tx_active && !stall_now && !loaded_q; // see R13
    // iso and forced packets need no handshake; others wait for the ack
    assign sent_done = (send_now && (iso_q || tog_force_q)) // see R1 see R4
                     || (wait_ack_q && link.ack);
    assign flush_now = I_CSR_WE && wd[uep_pkg::B_DISCARD] && loaded_q; // see R10 see R11
    assign load_now = I_CSR_WE && wd[uep_pkg::B_LOADED] && !loaded_q;
    assign tog_flip = (wait_ack_q && link.ack) || (send_now && tog_force_q); // see R18 see R4
    assign drop_one = sent_done || flush_now;

    // ****************************************************************
    // software written control bits
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            iso_q <= 1'b0; // see R17
            dir_tx_q <= 1'b0;
            dma_en_q <= 1'b0;
            tog_force_q <= 1'b0;
            dma_style_q <= 1'b0;
            halt_req_q <= 1'b0;
        end
        else if (I_CSR_WE)
        begin
            iso_q <= wd[uep_pkg::B_ISO]; // see R1
            dir_tx_q <= wd[uep_pkg::B_DIR_TX]; // see R2
            dma_en_q <= wd[uep_pkg::B_DMA_EN]; // see R3
            tog_force_q <= wd[uep_pkg::B_TOG_FORCE];
            dma_style_q <= wd[uep_pkg::B_DMA_STYLE]; // stored only; see R5
            halt_req_q <= wd[uep_pkg::B_HALT_REQ]; // see R8
        end
    end

    // ****************************************************************
    // packet loaded bit and packet count
    // ****************************************************************
    always_comb
    begin
        loaded_d = loaded_q;
        if (stall_now || drop_one)
        begin
            loaded_d = 1'b0; // see R7 see R10 see R15
        end
        else if (load_now)
        begin
            loaded_d = 1'b1; // see R15
        end
    end

    always_comb
    begin
        cnt_d = cnt_q;
        if (stall_now)
        begin
            cnt_d = 2'h0; // see R7
        end
        else if (load_now && !drop_one && cnt_q < 2'(SLOTS))
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (drop_one && !load_now && cnt_q != 2'h0)
        begin
            cnt_d = cnt_q - 2'h1; // see R10 see R12
        end
    end

    // set wins over a software clear in the same cycle
    assign has_pkt_d = (cnt_d != 2'h0)
                     || (has_pkt_q && !(I_CSR_WE && !wd[uep_pkg::B_HAS_PKT])); // see R14

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            loaded_q <= 1'b0;
            cnt_q <= 2'h0;
            has_pkt_q <= 1'b0;
        end
        else
        begin
            loaded_q <= loaded_d;
            cnt_q <= cnt_d;
            has_pkt_q <= has_pkt_d;
        end
    end

    // ****************************************************************
    // hardware set flags, cleared by writing zero
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            halt_rep_q <= 1'b0;
            underrun_q <= 1'b0;
        end
        else
        begin
            halt_rep_q <= stall_now // see R7
                       || (halt_rep_q && !(I_CSR_WE && !wd[uep_pkg::B_HALT_REP]));
            underrun_q <= under_now // see R13
                       || (underrun_q && !(I_CSR_WE && !wd[uep_pkg::B_UNDERRUN]));
        end
    end

    // ****************************************************************
    // data toggle and handshake wait
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            toggle_q <= 1'b0;
        end
        else if (I_CSR_WE && wd[uep_pkg::B_TOG_ZERO])
        begin
            toggle_q <= 1'b0; // see R6
        end
        else if (tog_flip)
        begin
            toggle_q <= !toggle_q; // see R18 see R4
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            wait_ack_q <= 1'b0;
        end
        else if (send_now && !iso_q && !tog_force_q)
        begin
            wait_ack_q <= 1'b1;
        end
        else if (link.ack || link.in_token || stall_now)
        begin
            wait_ack_q <= 1'b0; // a new token means a retry of the same packet
        end
    end

    // ****************************************************************
    // answer on the link
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            link.resp_valid <= 1'b0;
            link.resp_code <= uep_pkg::RESP_NAK;
        end
        else
        begin
            link.resp_valid <= link.in_token;
            if (stall_now)
            begin
                link.resp_code <= uep_pkg::RESP_STALL; // see R8
            end
            else if (send_now)
            begin
                link.resp_code <= toggle_q ? uep_pkg::RESP_DATA1 : uep_pkg::RESP_DATA0;
            end
            else
            begin
                link.resp_code <= uep_pkg::RESP_NAK;
            end
        end
    end

    // ****************************************************************
    // user side outputs
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            O_CSR_RDATA <= uep_pkg::CSR_RESET;
            O_IRQ <= 1'b0;
            O_DMA_REQ <= 1'b0;
            O_DIR_TX <= 1'b0;
            O_FIFO_RST <= 1'b0;
            O_PKT_COUNT <= 2'h0;
        end
        else
        begin
            // reserved bits and the toggle-zero strobe read zero; see R17 see R6
            O_CSR_RDATA <= {1'b0, iso_q, dir_tx_q, dma_en_q, tog_force_q,
                            dma_style_q, 3'h0, 1'b0, halt_rep_q, halt_req_q,
                            1'b0, underrun_q, has_pkt_q, loaded_q};
            O_IRQ <= loaded_q && !loaded_d && I_IRQ_EN; // see R16
            O_DMA_REQ <= dma_en_q && tx_active && !loaded_d; // see R3
            O_DIR_TX <= tx_active;
            O_FIFO_RST <= stall_now || flush_now; // see R7 see R10
            O_PKT_COUNT <= cnt_d;
        end
    end
endmodule // uep_dev_end
`default_nettype wire

// ==== verilog/uep_host_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module uep_host_end
(
    uep_link_if.host link, // token link to the device
    input wire logic I_CLK_SYS, // system clock
    input wire logic I_SRST, // synchronous reset, active high
    input wire logic [3:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [3:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    output logic O_IRQ // level interrupt
);
    logic aw_got_q, w_got_q, auto_ack_q, issue_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [uep_pkg::STAT_W-1:0] stat_q, mask_q, ev;
    logic [1:0] last_q;
    logic do_wr, rd_stat, got_data;
    uep_pkg::uep_host_st_t st_q;

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    assign S_AXI_AWREADY = !aw_got_q && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got_q && !S_AXI_BVALID;
    assign do_wr = aw_got_q && w_got_q && !S_AXI_BVALID;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= uep_pkg::AXI_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
            end
            if (do_wr)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_q == uep_pkg::OFS_CTRL || awaddr_q == uep_pkg::OFS_MASK)
                             ? uep_pkg::AXI_OKAY : uep_pkg::AXI_SLVERR;
            end
            else if (S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            auto_ack_q <= 1'b0;
            mask_q <= '0;
            issue_q <= 1'b0;
        end
        else
        begin
            issue_q <= do_wr && awaddr_q == uep_pkg::OFS_CTRL && S_AXI_WSTRB[0]
                     && wdata_q[uep_pkg::C_ISSUE];
            if (do_wr && awaddr_q == uep_pkg::OFS_CTRL && S_AXI_WSTRB[0])
            begin
                auto_ack_q <= wdata_q[uep_pkg::C_AUTO_ACK];
            end
            if (do_wr && awaddr_q == uep_pkg::OFS_MASK && S_AXI_WSTRB[0])
            begin
                mask_q <= wdata_q[uep_pkg::STAT_W-1:0];
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel; a status read clears it
    // ****************************************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_stat = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == uep_pkg::OFS_STAT;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= uep_pkg::AXI_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= uep_pkg::AXI_OKAY;
            case (S_AXI_ARADDR)
                uep_pkg::OFS_CTRL: S_AXI_RDATA <= {30'h0, auto_ack_q, st_q != uep_pkg::HS_IDLE};
                uep_pkg::OFS_STAT: S_AXI_RDATA <= {29'h0, stat_q};
                uep_pkg::OFS_MASK: S_AXI_RDATA <= {29'h0, mask_q};
                uep_pkg::OFS_LAST: S_AXI_RDATA <= {30'h0, last_q};
                default:
                begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= uep_pkg::AXI_SLVERR;
                end
            endcase
        end
        else if (S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // token sequencer
    // ****************************************************************
    assign got_data = link.resp_valid && (link.resp_code == uep_pkg::RESP_DATA0
                                       || link.resp_code == uep_pkg::RESP_DATA1);

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            st_q <= uep_pkg::HS_IDLE;
            link.in_token <= 1'b0;
            link.ack <= 1'b0;
            last_q <= 2'h0;
        end
        else
        begin
            link.in_token <= 1'b0;
            link.ack <= 1'b0;
            case (st_q)
                uep_pkg::HS_IDLE:
                begin
                    if (issue_q)
                    begin
                        link.in_token <= 1'b1;
                        st_q <= uep_pkg::HS_WAIT;
                    end
                end
                uep_pkg::HS_WAIT:
                begin
                    if (link.resp_valid)
                    begin
                        last_q <= link.resp_code;
                        st_q <= (got_data && auto_ack_q) ? uep_pkg::HS_ACK : uep_pkg::HS_IDLE;
                    end
                end
                uep_pkg::HS_ACK:
                begin
                    link.ack <= 1'b1;
                    st_q <= uep_pkg::HS_IDLE;
                end
                default: st_q <= uep_pkg::HS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // sticky status and interrupt; new events win over the read clear
    // ****************************************************************
    assign ev[uep_pkg::S_DATA] = got_data;
    assign ev[uep_pkg::S_STALL] = link.resp_valid && link.resp_code == uep_pkg::RESP_STALL;
    assign ev[uep_pkg::S_NAK] = link.resp_valid && link.resp_code == uep_pkg::RESP_NAK;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            stat_q <= '0;
            O_IRQ <= 1'b0;
        end
        else
        begin
            stat_q <= ev | (rd_stat ? '0 : stat_q);
            O_IRQ <= |((ev | (rd_stat ? '0 : stat_q)) & mask_q);
        end
    end
endmodule // uep_host_end
`default_nettype wire

// ==== verilog/uep_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface uep_link_if;
    logic in_token;
    logic ack;
    logic resp_valid;
    uep_pkg::uep_resp_t resp_code;

    modport dev
    (
        input in_token,
        input ack,
        output resp_valid,
        output resp_code
    );
    modport host
    (
        output in_token,
        output ack,
        input resp_valid,
        input resp_code
    );
endinterface
`default_nettype wire

// ==== verilog/uep_pkg.sv ====
package uep_pkg;
    // ****************************************************************
    // control/status register layout of the device transmit endpoint
    // ****************************************************************
    localparam int CSR_W = 16;
    localparam int B_ISO = 14;
    localparam int B_DIR_TX = 13;
    localparam int B_DMA_EN = 12;
    localparam int B_TOG_FORCE = 11;
    localparam int B_DMA_STYLE = 10;
    localparam int B_TOG_ZERO = 6;
    localparam int B_HALT_REP = 5;
    localparam int B_HALT_REQ = 4;
    localparam int B_DISCARD = 3;
    localparam int B_UNDERRUN = 2;
    localparam int B_HAS_PKT = 1;
    localparam int B_LOADED = 0;
    localparam logic [15:0] CSR_RESET = 16'h0000;
    localparam int PKT_SLOTS = 2;

    // ****************************************************************
    // link answer codes
    // ****************************************************************
    typedef enum logic [1:0]
    {
        RESP_NAK = 2'h0,
        RESP_DATA0 = 2'h1,
        RESP_DATA1 = 2'h2,
        RESP_STALL = 2'h3
    } uep_resp_t;

    // ****************************************************************
    // controller register map (AXI4-Lite, byte addresses)
    // ****************************************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_LAST = 4'hc;
    localparam int C_ISSUE = 0;
    localparam int C_AUTO_ACK = 1;
    localparam int S_DATA = 0;
    localparam int S_STALL = 1;
    localparam int S_NAK = 2;
    localparam int STAT_W = 3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        HS_IDLE = 2'h0,
        HS_WAIT = 2'h1,
        HS_ACK = 2'h3
    } uep_host_st_t;
endpackage
